// ==== hw/lpmc_pkg.sv ====
package lpmc_pkg;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Voltage ranges and clock sources
  // ----------------------------------------
  localparam logic [1:0] RANGE_1 = 2'h1;
  localparam logic [1:0] RANGE_2 = 2'h2;
  localparam logic [1:0] RANGE_3 = 2'h3;

  localparam logic [1:0] SRC_MULTISPEED = 2'h0;
  localparam logic [1:0] SRC_FAST_INT   = 2'h1;
  localparam logic [1:0] SRC_FAST_XTAL  = 2'h2;
  localparam logic [1:0] SRC_PLL        = 2'h3;

  // ----------------------------------------
  // Frequency limits in kHz
  // ----------------------------------------
  localparam logic [15:0] FMAX_R1_KHZ     = 16'h7d00; // 32 MHz
  localparam logic [15:0] FMAX_R2_KHZ     = 16'h3e80; // 16 MHz
  localparam logic [15:0] FMAX_R3_KHZ     = 16'h0fa0; // 4 MHz
  localparam logic [15:0] WAIT_R1_KHZ     = 16'h3e80; // 16 MHz
  localparam logic [15:0] WAIT_R2_KHZ     = 16'h1f40; // 8 MHz
  localparam logic [15:0] WAIT_R3_KHZ     = 16'h0834; // 2.1 MHz
  localparam logic [15:0] LP_RUN_MAX_KHZ  = 16'h0083; // 131 kHz

  // ----------------------------------------
  // Requested low-power mode encodings
  // ----------------------------------------
  localparam logic [2:0] REQ_SLEEP      = 3'h0;
  localparam logic [2:0] REQ_LP_SLEEP   = 3'h1;
  localparam logic [2:0] REQ_STOP_RTC   = 3'h2;
  localparam logic [2:0] REQ_STOP       = 3'h3;
  localparam logic [2:0] REQ_STBY_RTC   = 3'h4;
  localparam logic [2:0] REQ_STBY       = 3'h5;

  // ----------------------------------------
  // Wakeup latencies
  // ----------------------------------------
  localparam int CLK_MHZ          = 50;
  localparam int STOP_WAKE_US     = 8;
  localparam int STBY_WAKE_US     = 60;
  localparam int STOP_WAKE_CYC    = STOP_WAKE_US * CLK_MHZ;  // Sampling edge to Run, whole limit
  localparam int STBY_WAKE_CYC    = STBY_WAKE_US * CLK_MHZ;
  // Entry into Wake and the final zero count each cost one cycle of the limit
  localparam logic [11:0] STOP_WAKE_CNT = 12'(STOP_WAKE_CYC - 2);
  localparam logic [11:0] STBY_WAKE_CNT = 12'(STBY_WAKE_CYC - 2);

  typedef enum logic [2:0] {
    LPMC_RUN, LPMC_SLEEP, LPMC_LP_SLEEP, LPMC_STOP, LPMC_STBY, LPMC_WAKE
  } lpmc_mode_e;

endpackage : lpmc_pkg

// ==== hw/lpmc_ctrl.sv ====
// Notes on behaviour
// - Range 1 allows CPU clock up to 32 MHz.
// - Range 2 limits CPU clock to 16 MHz.
// - Range 3 limits CPU clock to 4 MHz, multispeed oscillator only.
// - One flash wait state above 16/8/2.1 MHz per range, else zero.
// - Sleep halts only CPU clock; any peripheral interrupt or event wakes.
// - Low-power Run needs multispeed below 131 kHz and low-power regulator.
// - Wake from low-power Sleep returns to Run with regulator normal.
// - Stop with RTC stops core clocks and fast oscillators, keeps slow one.
// - Stop with RTC wakes within 8 us on lines, detector, comparators, RTC, USB.
// - Stop without RTC kills all oscillators; wakes on lines, detector, comparators, USB.
// - Standby powers off core domain; only standby circuitry keeps state.
// - Standby with RTC exits within 60 us on reset, watchdog, wakeup pin, RTC.
// - Standby without RTC exits only on reset pin or wakeup pin edge.
// - Stop and Standby with RTC keep RTC, watchdog and their clocks running; without RTC they stop them.
module lpmc_ctrl
  import lpmc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Configuration from software
  input  wire logic [1:0]  range_sel,
  input  wire logic [1:0]  clk_src_sel,
  input  wire logic [15:0] cpu_freq_khz,
  input  wire logic [2:0]  lp_mode_req,
  input  wire logic        lp_run_req,
  input  wire logic        lp_regulator_req,
  // CPU core
  input  wire logic        wait_entry,
  // Wakeup sources
  input  wire logic        periph_event,
  input  wire logic [15:0] external_event_lines,
  input  wire logic        supply_threshold_detector,
  input  wire logic [1:0]  comparator_event,
  input  wire logic        usb_wakeup,
  input  wire logic        rtc_event,
  input  wire logic        independent_watchdog_reset,
  input  wire logic [1:0]  wakeup_pin,
  input  wire logic        external_reset_pin_n,
  // Clock and power controls
  output logic             cpu_clk_en,
  output logic             core_clk_en,
  output logic             core_power_en,
  output logic             regulator_lp,
  output logic             pll_en,
  output logic             multispeed_oscillator_en,
  output logic             fast_internal_oscillator_en,
  output logic             fast_crystal_oscillator_en,
  output logic             slow_osc_en,
  output logic             rtc_wdg_keep,
  output logic             retain_state,
  // Status
  output logic             flash_wait_states,
  output logic             freq_ok,
  output logic             lp_run_ok,
  output logic             standby_exit,
  output logic [2:0]       power_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  import lpmc_pkg::*;

  typedef struct packed {
    lpmc_mode_e  mode;
    logic        rtc_kept;
    logic [11:0] cnt;
    logic [1:0]  pin_prev;
    logic        cpu_clk_en;
    logic        core_clk_en;
    logic        core_power_en;
    logic        regulator_lp;
    logic        pll_en;
    logic        ms_en;
    logic        fi_en;
    logic        fx_en;
    logic        slow_en;
    logic        wait_st;
    logic        freq_ok;
    logic        lp_run_ok;
    logic        stby_exit;
  } lpmc_state_s;

  lpmc_state_s s_q;
  lpmc_state_s s_d;

  // ----------------------------------------
  // Range checks
  // ----------------------------------------
  // Ceiling on CPU clock for a range
  function automatic logic [15:0] lpmc_fmax(input logic [1:0] r);
    case (r)
      RANGE_1: lpmc_fmax = FMAX_R1_KHZ;
      RANGE_2: lpmc_fmax = FMAX_R2_KHZ;
      default: lpmc_fmax = FMAX_R3_KHZ;
    endcase
  endfunction : lpmc_fmax

  // Wait-state threshold for a range
  function automatic logic [15:0] lpmc_wait_thr(input logic [1:0] r);
    case (r)
      RANGE_1: lpmc_wait_thr = WAIT_R1_KHZ;
      RANGE_2: lpmc_wait_thr = WAIT_R2_KHZ;
      default: lpmc_wait_thr = WAIT_R3_KHZ;
    endcase
  endfunction : lpmc_wait_thr

  logic [15:0] rising_pins;
  logic        stop_wake;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_d          = s_q;
    rising_pins  = {14'h0000, wakeup_pin & ~s_q.pin_prev};
    s_d.pin_prev = wakeup_pin;
    s_d.stby_exit = 1'b0;
    // Frequency ceiling, source restriction and wait states
    s_d.freq_ok = (cpu_freq_khz <= lpmc_fmax(range_sel)) &&
                  ((range_sel != RANGE_3) || (clk_src_sel == SRC_MULTISPEED));
    s_d.wait_st = cpu_freq_khz > lpmc_wait_thr(range_sel);
    s_d.lp_run_ok = lp_run_req && (clk_src_sel == SRC_MULTISPEED) &&
                    (cpu_freq_khz < LP_RUN_MAX_KHZ) && lp_regulator_req;
    stop_wake = (|external_event_lines) || supply_threshold_detector ||
                (|comparator_event) || usb_wakeup || (s_q.rtc_kept && rtc_event);
    case (s_q.mode)
      LPMC_RUN: begin
        s_d.cpu_clk_en    = 1'b1;
        s_d.core_clk_en   = 1'b1;
        s_d.core_power_en = 1'b1;
        s_d.regulator_lp  = s_d.lp_run_ok;
        s_d.ms_en         = 1'b1;
        s_d.fi_en         = (clk_src_sel == SRC_FAST_INT) && !s_d.lp_run_ok;
        s_d.fx_en         = (clk_src_sel == SRC_FAST_XTAL) && !s_d.lp_run_ok;
        s_d.pll_en        = (clk_src_sel == SRC_PLL) && !s_d.lp_run_ok;
        s_d.slow_en       = 1'b1;
        if (wait_entry) begin
          s_d.cpu_clk_en = 1'b0;
          s_d.rtc_kept   = (lp_mode_req == REQ_STOP_RTC) || (lp_mode_req == REQ_STBY_RTC);
          case (lp_mode_req)
            REQ_SLEEP: s_d.mode = LPMC_SLEEP;
            REQ_LP_SLEEP: begin
              s_d.mode         = LPMC_LP_SLEEP;
              s_d.regulator_lp = 1'b1;
            end
            REQ_STOP_RTC, REQ_STOP: begin
              s_d.mode         = LPMC_STOP;
              s_d.core_clk_en  = 1'b0;
              s_d.regulator_lp = 1'b1;
              s_d.pll_en       = 1'b0;
              s_d.ms_en        = 1'b0;
              s_d.fi_en        = 1'b0;
              s_d.fx_en        = 1'b0;
              s_d.slow_en      = s_d.rtc_kept;
            end
            default: begin
              s_d.mode          = LPMC_STBY;
              s_d.core_clk_en   = 1'b0;
              s_d.core_power_en = 1'b0;
              s_d.pll_en        = 1'b0;
              s_d.ms_en         = 1'b0;
              s_d.fi_en         = 1'b0;
              s_d.fx_en         = 1'b0;
              s_d.slow_en       = s_d.rtc_kept;
            end
          endcase
        end
      end
      LPMC_SLEEP: begin
        if (periph_event || stop_wake) begin
          s_d.mode       = LPMC_RUN;
          s_d.cpu_clk_en = 1'b1;
        end
      end
      LPMC_LP_SLEEP: begin
        if (periph_event || stop_wake) begin
          s_d.mode         = LPMC_RUN;
          s_d.cpu_clk_en   = 1'b1;
          s_d.regulator_lp = 1'b0;
        end
      end
      LPMC_STOP: begin
        if (stop_wake) begin
          s_d.mode = LPMC_WAKE;
          s_d.cnt  = STOP_WAKE_CNT;
          s_d.ms_en = 1'b1;
        end
      end
      LPMC_STBY: begin
        if (!external_reset_pin_n || (|rising_pins) ||
            (s_q.rtc_kept && (rtc_event || independent_watchdog_reset))) begin
          s_d.mode          = LPMC_WAKE;
          s_d.cnt           = STBY_WAKE_CNT;
          s_d.core_power_en = 1'b1;
          s_d.ms_en         = 1'b1;
          s_d.stby_exit     = 1'b1;                                             // Core restarts from reset
        end
      end
      LPMC_WAKE: begin
        // Restart latency, bounded by the wake figures
        if (s_q.cnt == 12'h000) begin
          s_d.mode          = LPMC_RUN;
          s_d.core_clk_en   = 1'b1;
          s_d.cpu_clk_en    = 1'b1;
          s_d.regulator_lp  = 1'b0;
          s_d.slow_en       = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 12'h001;
        end
      end
      default: s_d.mode = LPMC_RUN;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q               <= '0;
      s_q.mode          <= LPMC_RUN;
      s_q.cpu_clk_en    <= 1'b1;
      s_q.core_clk_en   <= 1'b1;
      s_q.core_power_en <= 1'b1;
      s_q.ms_en         <= 1'b1;
      s_q.slow_en       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign cpu_clk_en                  = s_q.cpu_clk_en;
  assign core_clk_en                 = s_q.core_clk_en;
  assign core_power_en               = s_q.core_power_en;
  assign regulator_lp                = s_q.regulator_lp;
  assign pll_en                      = s_q.pll_en;
  assign multispeed_oscillator_en    = s_q.ms_en;
  assign fast_internal_oscillator_en = s_q.fi_en;
  assign fast_crystal_oscillator_en  = s_q.fx_en;
  assign slow_osc_en                 = s_q.slow_en;
  assign rtc_wdg_keep                = s_q.slow_en;
  assign retain_state                = s_q.core_power_en;
  assign flash_wait_states           = s_q.wait_st;
  assign freq_ok                     = s_q.freq_ok;
  assign lp_run_ok                   = s_q.lp_run_ok;
  assign standby_exit                = s_q.stby_exit;
  assign power_mode                  = s_q.mode;

endmodule : lpmc_ctrl

// ==== tb/lpmc_ctrl_sva.sv ====
module lpmc_ctrl_chk (
  // Clock, reset and causes
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [1:0]  range_sel,
  input wire logic [15:0] cpu_freq_khz,
  input wire logic        periph_event,
  input wire logic [15:0] external_event_lines,
  // Outputs under watch
  input wire logic        cpu_clk_en,
  input wire logic        core_clk_en,
  input wire logic        core_power_en,
  input wire logic        regulator_lp,
  input wire logic        pll_en,
  input wire logic        multispeed_oscillator_en,
  input wire logic        flash_wait_states,
  input wire logic        freq_ok,
  input wire logic        standby_exit,
  input wire logic [2:0]  power_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  import lpmc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Frequency limits and wait states
  // ----------------------------------------
  a_range1_ceiling: assert property (range_sel == RANGE_1 && cpu_freq_khz <= FMAX_R1_KHZ |=> freq_ok)
    else $error("range 1 frequency flagged");
  a_range2_ceiling: assert property (range_sel == RANGE_2 && cpu_freq_khz > FMAX_R2_KHZ |=> !freq_ok)
    else $error("range 2 overspeed not flagged");
  a_range3_ceiling: assert property (range_sel == RANGE_3 && cpu_freq_khz > FMAX_R3_KHZ |=> !freq_ok)
    else $error("range 3 overspeed not flagged");
  a_wait_state_r1: assert property (range_sel == RANGE_1 |=>
    flash_wait_states == ($past(cpu_freq_khz) > WAIT_R1_KHZ))
    else $error("range 1 wait state wrong");

  // ----------------------------------------
  // Mode enables and exits
  // ----------------------------------------
  a_sleep_cpu_only: assert property (power_mode == 3'h1 |-> !cpu_clk_en && core_clk_en && core_power_en)
    else $error("sleep clocks wrong");
  a_stop_clocks_off: assert property (power_mode == 3'h3 |->
    !core_clk_en && !pll_en && !multispeed_oscillator_en && regulator_lp)
    else $error("stop clocks wrong");
  a_stop_wake_time: assert property (power_mode == 3'h3 && |external_event_lines |=>
    power_mode == 3'h5 ##[1:399] power_mode == 3'h0)
    else $error("stop wake too slow");
  a_lp_sleep_exit: assert property (power_mode == 3'h2 && periph_event |=>
    power_mode == 3'h0 && !regulator_lp)
    else $error("low-power sleep exit wrong");
  a_standby_off: assert property (power_mode == 3'h4 |-> !core_power_en && !cpu_clk_en && !pll_en)
    else $error("standby power not off");
  a_exit_pulse: assert property (standby_exit |=> !standby_exit)
    else $error("standby exit not a pulse");

  // Main scenarios reached
  c_stop_wake: cover property (power_mode == 3'h3 ##1 power_mode == 3'h5);
  c_stby_exit: cover property (standby_exit);
  c_lp_sleep: cover property (power_mode == 3'h2 && periph_event);
endmodule : lpmc_ctrl_chk

bind lpmc_ctrl lpmc_ctrl_chk u_chk (
  .clock(clock), .rst_n(rst_n), .range_sel(range_sel), .cpu_freq_khz(cpu_freq_khz),
  .periph_event(periph_event), .external_event_lines(external_event_lines),
  .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en), .core_power_en(core_power_en),
  .regulator_lp(regulator_lp), .pll_en(pll_en), .multispeed_oscillator_en(multispeed_oscillator_en),
  .flash_wait_states(flash_wait_states), .freq_ok(freq_ok), .standby_exit(standby_exit),
  .power_mode(power_mode)
);

// ==== tb/lpmc_cpu_model.sv ====
module lpmc_cpu_model (
  // Commands from the bench
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [2:0] mode_in,
  // Toward the controller
  output logic      [2:0] lp_mode_req,
  output logic            wait_entry
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] step_q = 2'h0;
  initial lp_mode_req = 3'h0;
  initial wait_entry = 1'b0;
  // Mode is programmed one cycle ahead of the wait instruction
  always @(posedge clock) begin
    wait_entry <= 1'b0;
    if (go && step_q == 2'h0) begin
      lp_mode_req <= mode_in;
      step_q      <= 2'h1;
    end else if (step_q == 2'h1) begin
      wait_entry <= 1'b1;
      step_q     <= 2'h2;
    end else if (!go) begin
      step_q <= 2'h0;
    end
  end
endmodule : lpmc_cpu_model

// ==== tb/tb_low_power_mode_controller.sv ====
module tb_low_power_mode_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import lpmc_pkg::*;
  logic clock = 0, rst_n = 0, go = 0, lp_run_req = 0, lp_regulator_req = 0, wait_entry;
  logic periph_event = 0, supply_threshold_detector = 0, usb_wakeup = 0, rtc_event = 0;
  logic independent_watchdog_reset = 0, external_reset_pin_n = 1, saw = 0;
  logic [1:0] range_sel = 1, clk_src_sel = 0, comparator_event = 0, wakeup_pin = 0;
  logic [2:0] mode_in = 0, lp_mode_req, power_mode;
  logic [15:0] cpu_freq_khz = 16'h0fa0, external_event_lines = 0;
  logic cpu_clk_en, core_clk_en, core_power_en, regulator_lp, pll_en, multispeed_oscillator_en;
  logic fast_internal_oscillator_en, fast_crystal_oscillator_en, slow_osc_en, rtc_wdg_keep;
  logic retain_state, flash_wait_states, freq_ok, lp_run_ok, standby_exit;
  logic [3:0] osc;
  int err_count = 0, checks_done = 0, r, s, f, n, lim;
  int lims [6] = '{32000, 16000, 4000, 8000, 2100, 131};
  logic [2:0] pm_exp [6] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
  logic [3:0] en_exp [6] = '{4'h7, 4'h7, 4'h3, 4'h2, 4'h1, 4'h0};
  int src [6][3] = '{'{0, 1, 2}, '{0, 0, 0}, '{5, 1, 2}, '{3, 4, 1}, '{6, 5, 9}, '{7, 9, 8}};
  int bad [6] = '{-1, -1, -1, 5, 2, 1};

  lpmc_cpu_model u_cpu (.clock(clock), .go(go), .mode_in(mode_in), .lp_mode_req(lp_mode_req),
    .wait_entry(wait_entry));
  lpmc_ctrl DUT (.clock(clock), .rst_n(rst_n), .range_sel(range_sel), .clk_src_sel(clk_src_sel),
    .cpu_freq_khz(cpu_freq_khz), .lp_mode_req(lp_mode_req), .lp_run_req(lp_run_req),
    .lp_regulator_req(lp_regulator_req), .wait_entry(wait_entry), .periph_event(periph_event),
    .external_event_lines(external_event_lines), .supply_threshold_detector(supply_threshold_detector),
    .comparator_event(comparator_event), .usb_wakeup(usb_wakeup), .rtc_event(rtc_event),
    .independent_watchdog_reset(independent_watchdog_reset), .wakeup_pin(wakeup_pin),
    .external_reset_pin_n(external_reset_pin_n), .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en),
    .core_power_en(core_power_en), .regulator_lp(regulator_lp), .pll_en(pll_en),
    .multispeed_oscillator_en(multispeed_oscillator_en), .fast_internal_oscillator_en(fast_internal_oscillator_en),
    .fast_crystal_oscillator_en(fast_crystal_oscillator_en), .slow_osc_en(slow_osc_en),
    .rtc_wdg_keep(rtc_wdg_keep), .retain_state(retain_state), .flash_wait_states(flash_wait_states),
    .freq_ok(freq_ok), .lp_run_ok(lp_run_ok), .standby_exit(standby_exit), .power_mode(power_mode));

  always #10 clock = ~clock;

  // PLL, multispeed and fast oscillator enables seen together
  assign osc = {pll_en, multispeed_oscillator_en, fast_internal_oscillator_en, fast_crystal_oscillator_en};

  // Reference model of the frequency checks
  function automatic bit exp_ok(int r, int s, int f);
    return r == 1 ? f <= 32000 : r == 2 ? f <= 16000 : (f <= 4000 && s == 0);
  endfunction : exp_ok

  task automatic finish_test;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Drives one wake source to its active or idle level
  task automatic poke(int k, logic v);
    case (k)
      0: periph_event = v;
      1: external_event_lines = v ? 16'($urandom_range(65535, 1)) : 16'h0;
      2: supply_threshold_detector = v;
      3: comparator_event = v ? 2'h2 : 2'h0;
      4: usb_wakeup = v;
      5: rtc_event = v;
      6: independent_watchdog_reset = v;
      7: wakeup_pin = {1'b0, v};
      8: wakeup_pin = {v, 1'b0};
      default: external_reset_pin_n = !v;
    endcase
  endtask : poke

  // Bounded wait for a mode, counting falling edges
  task automatic wait_mode(logic [2:0] pm, int lim, output int n);
    n = 0;
    while (power_mode !== pm) begin
      @(negedge clock);
      n++;
      if (standby_exit === 1'b1) saw = 1;
      if (n > lim) begin
        chk(16'(n), 16'(lim));
        finish_test();
      end
    end
  endtask : wait_mode

  initial begin
    void'($urandom(38));
    repeat (2) @(posedge clock);
    @(negedge clock) rst_n = 1;
    // Random and boundary frequencies over all ranges and sources
    for (int i = 0; i < 60; i++) begin
      r = 1 + $urandom_range(2);
      s = $urandom_range(3);
      f = (i % 2) ? $urandom_range(34000) : lims[(i / 2) % 6] + $urandom_range(2) - 1;
      {range_sel, clk_src_sel, cpu_freq_khz} = {r[1:0], s[1:0], f[15:0]};
      {lp_run_req, lp_regulator_req} = (i % 5 == 4) ? 2'($urandom_range(2)) : 2'h3;
      @(negedge clock);
      @(negedge clock);
      chk(freq_ok, exp_ok(r, s, f));
      chk(flash_wait_states, f > (r == 1 ? 16000 : r == 2 ? 8000 : 2100));
      chk(lp_run_ok, lp_run_req && lp_regulator_req && s == 0 && f < 131);
    end
    {range_sel, clk_src_sel, cpu_freq_khz, lp_run_req} = {2'h1, 2'h0, 16'h0fa0, 1'b0};
    // Every mode, three wakes each, three sources except low-power Sleep; refused source first for Stop without RTC and both Standby modes
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 6; m++) begin
        lp_regulator_req = (m == 1);
        mode_in = 3'(m);
        go = 1;
        wait_mode(pm_exp[m], 10, n);
        go = 0;
        @(negedge clock);
        chk({cpu_clk_en, core_clk_en, core_power_en, slow_osc_en}, en_exp[m]);
        chk({rtc_wdg_keep, retain_state}, {en_exp[m][0], en_exp[m][1]});
        if (m < 4) chk(regulator_lp, m != 0);
        if (m > 1) chk(osc, 0);
        if (bad[m] >= 0) begin
          poke(bad[m], 1);
          repeat (5) @(negedge clock);
          chk(power_mode, pm_exp[m]);
          poke(bad[m], 0);
        end
        saw = 0;
        poke(src[m][k], 1);
        lim = m < 2 ? 1 : m < 4 ? STOP_WAKE_CYC : STBY_WAKE_CYC;
        wait_mode(3'h0, lim, n);
        poke(src[m][k], 0);
        chk(16'(n <= lim), 1);
        if (m > 3) chk(saw, 1);
        chk({cpu_clk_en, regulator_lp}, 2'h2);
        @(negedge clock);
      end
    end
    finish_test();
  end
endmodule : tb_low_power_mode_controller
